// [include/csc_map.svh]
// register offsets, field positions, reset values and timing counts
`ifndef CSC_MAP_SVH
`define CSC_MAP_SVH
`define CSC_OFF_CTRL      8'h00
`define CSC_OFF_STATUS    8'h04
`define CSC_OFF_UPPER     8'h08
`define CSC_OFF_LOWER     8'h0C
`define CSC_OFF_CAPTURE   8'h10
`define CSC_OFF_IRQ_STAT  8'h14
`define CSC_OFF_IRQ_MASK  8'h18
`define CSC_CTRL_RESET    16'h7003
`define CSC_CTRL_WMASK    16'h7303
`define CSC_UPPER_RESET   16'hFFFF
`define CSC_LOWER_RESET   16'h0000
`define CSC_BIT_MAIN_EN   0
`define CSC_BIT_SUB_EN    1
`define CSC_BIT_CHK_EN    8
`define CSC_BIT_RST_EN    9
`define CSC_PER_LO        12
`define CSC_PER_HI        14
`define CSC_IRQ_MAIN      0
`define CSC_IRQ_SUB       1
`define CSC_IRQ_FREQ      2
`define CSC_STOP_LIMIT    6'h20
`endif

// [include/csc_pkg.sv]
// types shared by the clock supervisor control logic
package csc_pkg;
  typedef struct packed {
    logic main_osc;
    logic sub_osc;
    logic hs_rc;
    logic ls_rc;
  } csc_osc_t;

  typedef enum logic [1:0] {
    CSC_CHK_IDLE = 2'b00,
    CSC_CHK_ARM  = 2'b01,
    CSC_CHK_MEAS = 2'b10
  } csc_chk_state_t;
endpackage : csc_pkg

// [hw/csc_ctrl.sv]
// clock supervisor: stop watch, frequency window check, axi4-lite registers
//
// Overview of operation
// - period code 101/110/111 picks hs rc divided by 256/512/1024
// - control bit 9 lets a repeated frequency fault request reset
// - control bit 8 runs the frequency window checker, off at reset
// - control bit 1 enables sub oscillator stop watch, on at reset
// - control bit 0 enables main oscillator stop watch, on at reset
// - reserved control bits read zero; software writes zeros
// - software reset keeps control and window registers
// - status bit 1 shows a detected sub oscillator failure
// - status bit 0 shows a detected main oscillator failure
// - status read returns flags then clears them; writes ignored
// - upper window limit is a read/write 16-bit value, reset FFFF
// - no edge within 32 rc clocks flags failure and requests reset
// - main edges counted per divided period; outside window is fault
// - first fault interrupts; second uncleared fault may request reset
// - an out-of-window count is kept in the captured count register
`timescale 1ns/1ps
`default_nettype none
`include "csc_map.svh"
module csc_ctrl (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        sw_reset,
  // clocks under watch, asynchronous to aclk
  input  wire logic        main_osc_in,
  input  wire logic        sub_osc_in,
  input  wire logic        hs_rc_in,
  input  wire logic        ls_rc_in,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // requests to interrupt and reset control
  output logic             irq,
  output logic             clk_fail_reset_req,
  output logic             freq_fault_reset_req
);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [9:0] period_last(input logic [2:0] code);
    case (code)
      3'h5:    period_last = 10'h0FF;
      3'h6:    period_last = 10'h1FF;
      default: period_last = 10'h3FF;
    endcase
  endfunction : period_last

  // registers
  logic [15:0] ctrl_q;
  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic [15:0] capture_q;
  logic [1:0]  fail_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_mask_q;

  // synchronisers and edge detect
  csc_pkg::csc_osc_t meta_q;
  csc_pkg::csc_osc_t sync_q;
  csc_pkg::csc_osc_t prev_q;
  csc_pkg::csc_osc_t rise;
  assign rise = sync_q & ~prev_q;

  always_ff @(posedge aclk) begin
    meta_q <= {main_osc_in, sub_osc_in, hs_rc_in, ls_rc_in};
    sync_q <= meta_q;
    prev_q <= sync_q;
  end

  // stop watch
  logic [5:0] main_cnt_q;
  logic [5:0] sub_cnt_q;
  logic       main_fail_ev;
  logic       sub_fail_ev;
  assign main_fail_ev = rise.hs_rc && !rise.main_osc
                        && main_cnt_q == `CSC_STOP_LIMIT - 6'h01;
  assign sub_fail_ev  = rise.ls_rc && !rise.sub_osc
                        && sub_cnt_q == `CSC_STOP_LIMIT - 6'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn || sw_reset) begin
      main_cnt_q <= 6'h00;
    end else if (!ctrl_q[`CSC_BIT_MAIN_EN] || rise.main_osc) begin
      main_cnt_q <= 6'h00;
    end else if (rise.hs_rc && main_cnt_q != `CSC_STOP_LIMIT) begin
      main_cnt_q <= main_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || sw_reset) begin
      sub_cnt_q <= 6'h00;
    end else if (!ctrl_q[`CSC_BIT_SUB_EN] || rise.sub_osc) begin
      sub_cnt_q <= 6'h00;
    end else if (rise.ls_rc && sub_cnt_q != `CSC_STOP_LIMIT) begin
      sub_cnt_q <= sub_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_fail_reset_req <= 1'b0;
    end else begin
      clk_fail_reset_req <= main_fail_ev || sub_fail_ev;
    end
  end

  // frequency window checker
  csc_pkg::csc_chk_state_t chk_q;
  logic [9:0]  div_q;
  logic [15:0] meas_q;
  logic        period_edge;
  logic        chk_run;
  logic        freq_fault_ev;
  logic [15:0] meas_now;
  // a stopped main clock makes the count meaningless, so stand down
  assign chk_run = ctrl_q[`CSC_BIT_CHK_EN]
                   && main_cnt_q != `CSC_STOP_LIMIT;
  assign period_edge = rise.hs_rc
                       && div_q == period_last(ctrl_q[`CSC_PER_HI:`CSC_PER_LO]);
  // edge landing on the period boundary still belongs to the old period
  assign meas_now = (rise.main_osc && meas_q != 16'hFFFF)
                    ? meas_q + 16'h0001 : meas_q;
  assign freq_fault_ev = chk_q == csc_pkg::CSC_CHK_MEAS && period_edge
                         && (meas_now < lower_q || meas_now > upper_q);

  always_ff @(posedge aclk) begin
    if (!aresetn || sw_reset || !chk_run) begin
      div_q <= 10'h000;
    end else if (period_edge) begin
      div_q <= 10'h000;
    end else if (rise.hs_rc) begin
      div_q <= div_q + 10'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || sw_reset) begin
      chk_q  <= csc_pkg::CSC_CHK_IDLE;
      meas_q <= 16'h0000;
    end else begin
      case (chk_q)
        csc_pkg::CSC_CHK_IDLE: begin
          meas_q <= 16'h0000;
          if (chk_run) begin
            chk_q <= csc_pkg::CSC_CHK_ARM;
          end
        end
        csc_pkg::CSC_CHK_ARM: begin
          // first period starts at an edge, not at the enable write
          meas_q <= 16'h0000;
          if (!chk_run) begin
            chk_q <= csc_pkg::CSC_CHK_IDLE;
          end else if (period_edge) begin
            chk_q <= csc_pkg::CSC_CHK_MEAS;
          end
        end
        csc_pkg::CSC_CHK_MEAS: begin
          if (!chk_run) begin
            chk_q  <= csc_pkg::CSC_CHK_IDLE;
            meas_q <= 16'h0000;
          end else if (period_edge) begin
            meas_q <= 16'h0000;
          end else begin
            meas_q <= meas_now;
          end
        end
        default: begin
          chk_q  <= csc_pkg::CSC_CHK_IDLE;
          meas_q <= 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_q <= 16'h0000;
    end else if (freq_fault_ev) begin
      capture_q <= meas_now;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || sw_reset) begin
      freq_fault_reset_req <= 1'b0;
    end else begin
      freq_fault_reset_req <= freq_fault_ev
                              && irq_stat_q[`CSC_IRQ_FREQ]
                              && ctrl_q[`CSC_BIT_RST_EN];
    end
  end

  // axi4-lite slave
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_full_q;
  logic        w_full_q;
  logic        wr_go;
  logic        rd_go;
  logic        stat_rd;
  logic [31:0] rd_mux;
  logic        rd_hit;
  assign wr_go   = aw_full_q && w_full_q && !s_axi_bvalid;
  assign rd_go   = s_axi_arvalid && s_axi_arready;
  assign stat_rd = rd_go && s_axi_araddr == `CSC_OFF_STATUS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q <= `CSC_OFF_IRQ_MASK
                         && awaddr_q[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `CSC_OFF_CTRL:     rd_mux[15:0] = ctrl_q;
      `CSC_OFF_STATUS:   rd_mux[7:0]  = {6'h00, fail_q};
      `CSC_OFF_UPPER:    rd_mux[15:0] = upper_q;
      `CSC_OFF_LOWER:    rd_mux[15:0] = lower_q;
      `CSC_OFF_CAPTURE:  rd_mux[15:0] = capture_q;
      `CSC_OFF_IRQ_STAT: rd_mux[2:0]  = irq_stat_q;
      `CSC_OFF_IRQ_MASK: rd_mux[2:0]  = irq_mask_q;
      default:           rd_hit       = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // software reset deliberately absent: settings survive it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= `CSC_CTRL_RESET;
      upper_q    <= `CSC_UPPER_RESET;
      lower_q    <= `CSC_LOWER_RESET;
      irq_mask_q <= 3'h0;
    end else if (wr_go) begin
      case (awaddr_q)
        `CSC_OFF_CTRL: ctrl_q <= 16'(merge({16'h0000, ctrl_q}, wdata_q,
                                           wstrb_q))
                                 & `CSC_CTRL_WMASK;
        `CSC_OFF_UPPER: upper_q <= 16'(merge({16'h0000, upper_q},
                                             wdata_q, wstrb_q));
        `CSC_OFF_LOWER: lower_q <= 16'(merge({16'h0000, lower_q},
                                             wdata_q, wstrb_q));
        `CSC_OFF_IRQ_MASK: begin
          if (wstrb_q[0]) begin
            irq_mask_q <= wdata_q[2:0];
          end
        end
        default: ;
      endcase
    end
  end

  // hardware set beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || sw_reset) begin
      fail_q <= 2'h0;
    end else begin
      fail_q <= (stat_rd ? 2'h0 : fail_q)
                | {sub_fail_ev, main_fail_ev};
    end
  end

  logic [2:0] irq_clr;
  assign irq_clr = (wr_go && awaddr_q == `CSC_OFF_IRQ_STAT && wstrb_q[0])
                   ? wdata_q[2:0] : 3'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn || sw_reset) begin
      irq_stat_q <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr)
                    | {freq_fault_ev, sub_fail_ev, main_fail_ev};
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule : csc_ctrl
`default_nettype wire

// [verification/csc_osc_model.sv]
// oscillator model: watched clocks, main and sub can be stopped
`timescale 1ns/1ps
`default_nettype none
module csc_osc_model (
  // run controls from the bench
  input  wire logic main_run,
  input  wire logic sub_run,
  // clocks to the supervisor
  output logic      main_osc,
  output logic      sub_osc,
  output logic      hs_rc,
  output logic      ls_rc
);
  // offsets keep every edge clear of the aclk sampling edge
  // a stopped oscillator stands low, as a dead crystal would
  initial begin
    main_osc = 1'b0;
    forever #20 main_osc = main_run ? ~main_osc : 1'b0;
  end
  initial begin
    sub_osc = 1'b0;
    #1;
    forever #25 sub_osc = sub_run ? ~sub_osc : 1'b0;
  end
  initial begin
    hs_rc = 1'b0;
    #2;
    forever #15 hs_rc = ~hs_rc;
  end
  initial begin
    ls_rc = 1'b0;
    #4;
    forever #35 ls_rc = ~ls_rc;
  end
endmodule : csc_osc_model
`default_nettype wire

// [verification/csc_ctrl_checker.sv]
// port assertions for the clock supervisor control block
`timescale 1ns/1ps
`default_nettype none
module csc_ctrl_checker (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        sw_reset,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // requests
  input wire logic        irq,
  input wire logic        clk_fail_reset_req,
  input wire logic        freq_fault_reset_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  rd_answer_a: assert property (ar_take_s
    |=> s_axi_rvalid && !s_axi_arready) else $error("read not answered");
  // both halves taken: slave latches, then answers one cycle later
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no bvalid");
  ctrl_rsvd_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
    |=> (s_axi_rdata & 32'hFFFF8CFC) == 32'h0)
    else $error("control reserved bits set");
  stat_rsvd_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04
    |=> s_axi_rdata[31:2] == 30'h0) else $error("status reserved bits set");
  bad_addr_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h1C
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("no slverr");
  swr_clear_a: assert property (sw_reset
    |=> !irq && !freq_fault_reset_req) else $error("soft reset kept request");
  freq_pulse_a: assert property (freq_fault_reset_req
    |=> !freq_fault_reset_req) else $error("freq request not a pulse");
  cover property (freq_fault_reset_req);
  cover property (clk_fail_reset_req);
  cover property (irq);
endmodule : csc_ctrl_checker
bind csc_ctrl csc_ctrl_checker u_chk (.aclk, .aresetn, .sw_reset,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .irq, .clk_fail_reset_req,
  .freq_fault_reset_req);
`default_nettype wire

// [verification/tb.sv]
// testbench: registers, stop watch and frequency window scenarios
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk, aresetn, sw_reset, main_run, sub_run, main_osc_in, sub_osc_in;
  logic hs_rc_in, ls_rc_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic clk_fail_reset_req, freq_fault_reset_req;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int failures, total_checks, cycles, n_clk, n_freq;
  csc_osc_model model (.main_run, .sub_run, .main_osc(main_osc_in),
    .sub_osc(sub_osc_in), .hs_rc(hs_rc_in), .ls_rc(ls_rc_in));
  csc_ctrl dut (.aclk, .aresetn, .sw_reset, .main_osc_in, .sub_osc_in,
    .hs_rc_in, .ls_rc_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq, .clk_fail_reset_req, .freq_fault_reset_req);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic stop_test;
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (clk_fail_reset_req) n_clk <= n_clk + 1;
    if (freq_fault_reset_req) n_freq <= n_freq + 1;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // bounded wait for the next pulse of one reset request
  task automatic wait_evt(input bit fq);
    int base;
    base = fq ? n_freq : n_clk;
    repeat (3000) begin
      @(posedge aclk);
      if ((fq ? n_freq : n_clk) != base) break;
    end
  endtask : wait_evt
  initial begin
    {aresetn, sw_reset, s_axi_awvalid, s_axi_wvalid} = 4'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {main_run, sub_run} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00); chk("ctrl_reset", 32'h7003, d);
    rd(8'h08); chk("upper_reset", 32'hFFFF, d);
    rd(8'h04); chk("status_reset", 32'h0, d);
    wr(8'h00, 32'hFFFF); rd(8'h00); chk("ctrl_rsvd", 32'h7303, d);
    wr(8'h04, 32'h3); rd(8'h04); chk("status_write", 32'h0, d);
    wr(8'h1C, 32'h1); chk("bad_write", 32'h2, {30'h0, r});
    wr(8'h08, 32'h1234);
    wr(8'h00, 32'h5003);
    @(posedge aclk) sw_reset <= 1'b1;
    @(posedge aclk) sw_reset <= 1'b0;
    rd(8'h00); chk("ctrl_swr", 32'h5003, d);
    rd(8'h08); chk("upper_swr", 32'h1234, d);
    rd(8'h1C); chk("unmapped", 32'h2, {30'h0, r});
    wr(8'h18, 32'h7);
    wr(8'h00, 32'h5002);
    main_run <= 1'b0;
    repeat (200) @(posedge aclk);
    rd(8'h04); chk("main_off", 32'h0, d);
    wr(8'h00, 32'h5003); wait_evt(0);
    chk("clk_req", 32'h1, n_clk);
    rd(8'h04); chk("main_fail", 32'h1, d);
    rd(8'h04); chk("status_rc", 32'h0, d);
    chk("irq_set", 32'h1, {31'h0, irq});
    main_run <= 1'b1;
    wr(8'h14, 32'h1);
    repeat (3) @(posedge aclk);
    chk("irq_clear", 32'h0, {31'h0, irq});
    sub_run <= 1'b0;
    wait_evt(0);
    rd(8'h04); chk("sub_fail", 32'h2, d);
    sub_run <= 1'b1;
    wr(8'h14, 32'h2);
    // window 170..250 around the 192 expected count; upper kept above lower
    wr(8'h0C, 32'hAA); wr(8'h08, 32'hFA);
    wr(8'h00, 32'h5103);
    repeat (2400) @(posedge aclk);
    rd(8'h14); chk("in_window", 32'h0, d);
    wr(8'h00, 32'h5003);
    wr(8'h08, 32'hB4);
    wr(8'h00, 32'h5103);
    repeat (2400) @(posedge aclk);
    rd(8'h14); chk("freq_fault", 32'h4, d);
    chk("no_freq_req", 32'h0, n_freq);
    rd(8'h10);
    chk("captured", 32'h1, {31'h0, d >= 32'hBE && d <= 32'hC2});
    wr(8'h00, 32'h5003);
    wr(8'h00, 32'h5303); wait_evt(1);
    chk("freq_req", 32'h1, n_freq);
    stop_test();
  end
endmodule : tb
`default_nettype wire
